// ---- sml_map.svh ----
// Constants for the subtract, move and logic execution block.
// Assumes an 18-bit instruction word and an 8-bit data path.
//
// Contract
// RQ1: Opcode 00000 writes destination minus source back to the destination, bits 2:0 zero.
// RQ2: Opcode 00001 subtracts the immediate in bits 7:0 from the destination.
// RQ3: Opcode 00010 writes destination minus source minus carry, bits 2:0 zero.
// RQ4: Opcode 00011 writes destination minus immediate minus carry.
// RQ5: Every subtraction sets carry when the result is negative and clears it otherwise.
// RQ6: Every instruction sets zero when all eight result bits are 0 and clears it otherwise.
// RQ7: Opcode 01000 copies the source register into the destination, carry untouched.
// RQ8: Opcode 01001 loads the immediate into the destination, carry untouched.
// RQ9: Opcode 01010 writes destination AND source, carry untouched.
// RQ10: Opcode 01011 writes destination AND immediate, carry untouched.
// RQ11: Opcode 01100 writes destination OR source, carry untouched.
// RQ12: Opcode 01101 writes destination OR immediate, carry untouched.
// RQ13: Opcode 01110 writes destination XOR source, carry untouched.
// RQ14: Opcode 01111 writes destination XOR immediate, carry untouched.
// RQ15: Each instruction, write and flags included, completes in two clock cycles.
// RQ16: Five-bit index fields select one of 32 registers of 8 bits each.
// RQ17: Negative means an unsigned borrow out of the 8-bit subtraction, carry-in included.
`ifndef SML_MAP_SVH
`define SML_MAP_SVH

// Widths and sizes
`define SML_DATA_W     8
`define SML_INDEX_W    5
`define SML_REG_COUNT  32
`define SML_INSTR_W    18

// Opcodes in bits 17:13
`define SML_OP_SUB      5'h00
`define SML_OP_SUB_K    5'h01
`define SML_OP_SUB_B    5'h02
`define SML_OP_SUB_KB   5'h03
`define SML_OP_COPY     5'h08
`define SML_OP_LOAD_K   5'h09
`define SML_OP_AND      5'h0A
`define SML_OP_AND_K    5'h0B
`define SML_OP_OR       5'h0C
`define SML_OP_OR_K     5'h0D
`define SML_OP_XOR      5'h0E
`define SML_OP_XOR_K    5'h0F

// Field of the register forms that must be zero
`define SML_PAD_ZERO    3'h0

// Reset values
`define SML_REG_RESET   8'h00
`define SML_CARRY_RESET 1'b0
`define SML_ZERO_RESET  1'b0

// Cycles from acceptance to completion
`define SML_EXEC_CYCLES 2

`endif

// ---- sml_pkg.sv ----
// Types for the subtract, move and logic execution block.
// Assumes sml_map.svh supplies all numeric constants.
`include "sml_map.svh"

package sml_pkg;

    // Instruction word split into opcode, destination and low byte
    typedef struct packed {
        logic [4:0] op;
        logic [4:0] dst;
        logic [7:0] low;
    } sml_instr_s;

    // Flag pair
    typedef struct packed {
        logic carry;
        logic zero;
    } sml_flags_s;

    // Sequencer state
    typedef enum logic {
        ST_IDLE,
        ST_EXEC
    } sml_state_e;

endpackage : sml_pkg

// ---- sml_alu.sv ----
// Execution datapath for subtract, move and bitwise logic instructions,
// with its own 32-entry register file and carry and zero flags.
// Assumes the fetch sequencer offers one instruction at a time on mclk
// and waits for the done pulse before offering the next.
`timescale 1ns/1ps
`include "sml_map.svh"

module sml_alu #(
    parameter int DATA_W    = `SML_DATA_W,
    parameter int REG_COUNT = `SML_REG_COUNT
) (
    input  wire logic                       mclk,        // Core clock, 25 MHz
    input  wire logic                       reset,       // Synchronous reset, high
    input  wire logic                       instrValid,  // Instruction offered
    input  wire logic [`SML_INSTR_W-1:0]    instrWord,   // Instruction word
    input  wire logic [`SML_INDEX_W-1:0]    peekIndex,   // Register to observe
    output logic                            busy,        // Instruction in flight
    output logic                            done,        // Completion pulse
    output logic                            illegal,     // Rejected encoding pulse
    output logic [DATA_W-1:0]               result,      // Last result
    output logic                            carryFlag,   // Carry flag
    output logic                            zeroFlag,    // Zero flag
    output logic [DATA_W-1:0]               peekData     // Observed register
);

    ////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////

    sml_pkg::sml_state_e    stateReg;
    sml_pkg::sml_state_e    stateNext;
    sml_pkg::sml_instr_s    instrReg;
    sml_pkg::sml_instr_s    instrNext;
    sml_pkg::sml_instr_s    offered;
    sml_pkg::sml_flags_s    flagsReg;
    sml_pkg::sml_flags_s    flagsNext;
    logic [DATA_W-1:0]      opAReg;
    logic [DATA_W-1:0]      opANext;
    logic [DATA_W-1:0]      opBReg;
    logic [DATA_W-1:0]      opBNext;
    logic [DATA_W-1:0]      resultReg;
    logic [DATA_W-1:0]      resultNext;
    logic                   busyReg;
    logic                   busyNext;
    logic                   doneReg;
    logic                   doneNext;
    logic                   illegalReg;
    logic                   illegalNext;
    logic [DATA_W-1:0]      peekReg;
    logic [DATA_W-1:0]      peekNext;
    logic [DATA_W-1:0]      regVal [REG_COUNT];
    logic [`SML_INDEX_W-1:0] srcIndex;
    logic [DATA_W-1:0]      operandB;
    logic [DATA_W:0]        diffWide;
    logic                   borrowIn;
    logic                   legal;
    logic                   isSub;
    logic [DATA_W-1:0]      aluOut;
    logic                   writeEn;

    // Field view of the offered word; the source index is used at acceptance
    assign offered  = sml_pkg::sml_instr_s'(instrWord);
    assign srcIndex = offered.low[7:3];

    ////////////////////////////////////////
    // Sequencer: accept, then execute
    ////////////////////////////////////////

    // Next state and operand capture
    always_comb
    begin
        stateNext = stateReg;
        instrNext = instrReg;
        opANext   = opAReg;
        opBNext   = opBReg;
        busyNext  = 1'b0;
        unique case (stateReg)
            sml_pkg::ST_IDLE:
            begin
                // RQ15 first of two cycles
                if (instrValid)
                begin
                    instrNext = offered;
                    // RQ16 index selects register
                    opANext   = regVal[offered.dst];
                    opBNext   = regVal[srcIndex];
                    stateNext = sml_pkg::ST_EXEC;
                    busyNext  = 1'b1;
                end
            end
            sml_pkg::ST_EXEC:
            begin
                // Offers seen here are ignored, not queued
                // RQ15 second cycle retires
                stateNext = sml_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            stateReg <= sml_pkg::ST_IDLE;
            instrReg <= '0;
            opAReg   <= `SML_REG_RESET;
            opBReg   <= `SML_REG_RESET;
            busyReg  <= 1'b0;
        end
        else
        begin
            stateReg <= stateNext;
            instrReg <= instrNext;
            opAReg   <= opANext;
            opBReg   <= opBNext;
            busyReg  <= busyNext;
        end
    end

    ////////////////////////////////////////
    // Decode and arithmetic
    ////////////////////////////////////////

    // Second operand: immediate for odd opcodes
    assign operandB = instrReg.op[0] ? instrReg.low : opBReg;
    assign isSub    = (instrReg.op[4:2] == 3'h0);
    // Carry is taken as the previous instruction left it
    // RQ3 borrow forms use carry
    assign borrowIn = instrReg.op[1] & flagsReg.carry;

    // Bit 8 is set exactly when the true difference is negative
    // RQ17 nine-bit unsigned difference
    assign diffWide = {1'b0, opAReg} - {1'b0, operandB}
                      - {{DATA_W{1'b0}}, borrowIn};

    // Operation select and legality
    always_comb
    begin
        legal  = 1'b1;
        aluOut = opAReg;
        unique case (instrReg.op)
            // RQ1 register subtract
            `SML_OP_SUB:    aluOut = diffWide[DATA_W-1:0];
            // RQ2 constant subtract
            `SML_OP_SUB_K:  aluOut = diffWide[DATA_W-1:0];
            // RQ3 register subtract with borrow
            `SML_OP_SUB_B:  aluOut = diffWide[DATA_W-1:0];
            // RQ4 constant subtract with borrow
            `SML_OP_SUB_KB: aluOut = diffWide[DATA_W-1:0];
            // RQ7 register copy
            `SML_OP_COPY:   aluOut = opBReg;
            // RQ8 constant load
            `SML_OP_LOAD_K: aluOut = instrReg.low;
            // RQ9 register AND
            `SML_OP_AND:    aluOut = opAReg & operandB;
            // RQ10 constant AND
            `SML_OP_AND_K:  aluOut = opAReg & operandB;
            // RQ11 register OR
            `SML_OP_OR:     aluOut = opAReg | operandB;
            // RQ12 constant OR
            `SML_OP_OR_K:   aluOut = opAReg | operandB;
            // RQ13 register XOR
            `SML_OP_XOR:    aluOut = opAReg ^ operandB;
            // RQ14 constant XOR
            `SML_OP_XOR_K:  aluOut = opAReg ^ operandB;
            default:        legal  = 1'b0;
        endcase
        // RQ1 register forms need zero pad
        if (!instrReg.op[0] && instrReg.low[2:0] != `SML_PAD_ZERO)
        begin
            legal = 1'b0;
        end
    end

    // A rejected word leaves registers, result and flags as they were
    // Write only on a legal instruction in its second cycle
    assign writeEn = (stateReg == sml_pkg::ST_EXEC) && legal;

    ////////////////////////////////////////
    // Flags, result and completion
    ////////////////////////////////////////

    // Next flag and status values
    always_comb
    begin
        flagsNext   = flagsReg;
        resultNext  = resultReg;
        doneNext    = 1'b0;
        illegalNext = 1'b0;
        if (stateReg == sml_pkg::ST_EXEC)
        begin
            doneNext    = 1'b1;
            illegalNext = !legal;
            if (legal)
            begin
                resultNext = aluOut;
                // RQ6 zero from result
                flagsNext.zero = (aluOut == '0);
                // Only subtracts touch carry; moves and logic keep it
                // RQ5 carry on borrow out
                if (isSub)
                begin
                    flagsNext.carry = diffWide[DATA_W];
                end
            end
        end
    end

    // Flag and status registers
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            flagsReg   <= {`SML_CARRY_RESET, `SML_ZERO_RESET};
            resultReg  <= `SML_REG_RESET;
            doneReg    <= 1'b0;
            illegalReg <= 1'b0;
        end
        else
        begin
            flagsReg   <= flagsNext;
            resultReg  <= resultNext;
            doneReg    <= doneNext;
            illegalReg <= illegalNext;
        end
    end

    ////////////////////////////////////////
    // Register file
    ////////////////////////////////////////

    // Operands are read at acceptance, one edge after the last write,
    // so back-to-back dependent instructions see fresh values
    // RQ16 thirty-two 8-bit entries
    for (genvar i = 0; i < REG_COUNT; i++)
    begin : gEntry
        logic [DATA_W-1:0] entryReg;
        logic [DATA_W-1:0] entryNext;

        // Destination write
        always_comb
        begin
            entryNext = entryReg;
            if (writeEn && instrReg.dst == i[`SML_INDEX_W-1:0])
            begin
                entryNext = aluOut;
            end
        end

        // Entry storage
        always_ff @(posedge mclk)
        begin
            if (reset)
            begin
                entryReg <= `SML_REG_RESET;
            end
            else
            begin
                entryReg <= entryNext;
            end
        end

        assign regVal[i] = entryReg;
    end

    ////////////////////////////////////////
    // Observation port
    ////////////////////////////////////////

    // Peek lags the file by one edge, like any registered read
    // Registered read of any entry
    always_comb
    begin
        peekNext = regVal[peekIndex];
    end

    // Observation register
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            peekReg <= `SML_REG_RESET;
        end
        else
        begin
            peekReg <= peekNext;
        end
    end

    ////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////

    // Result and flags hold until the next legal instruction
    // All outputs straight from flops
    assign busy      = busyReg;
    assign done      = doneReg;
    assign illegal   = illegalReg;
    assign result    = resultReg;
    assign carryFlag = flagsReg.carry;
    assign zeroFlag  = flagsReg.zero;
    assign peekData  = peekReg;

endmodule : sml_alu

// ---- sml_alu_monitor.sv ----
// Assertion checker for the execution block, bound to its ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`include "sml_map.svh"

module sml_alu_monitor #(
    parameter int DATA_W    = `SML_DATA_W,
    parameter int REG_COUNT = `SML_REG_COUNT
) (
    input wire logic              mclk,       // Clock
    input wire logic              reset,      // Reset
    input wire logic              instrValid, // Offered
    input wire logic [17:0]       instrWord,  // Word
    input wire logic [4:0]        peekIndex,  // Peek index
    input wire logic              busy,       // Executing
    input wire logic              done,       // Retired
    input wire logic              illegal,    // Rejected
    input wire logic [DATA_W-1:0] result,     // Result
    input wire logic              carryFlag,  // Carry
    input wire logic              zeroFlag,   // Zero
    input wire logic [DATA_W-1:0] peekData    // Peek data
);
    // One clock domain; reset aborts every check in flight
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    logic [4:0] opCap;  // Opcode in flight
    logic [7:0] immCap; // Immediate in flight
    logic       cinCap; // Carry taken in
    logic [8:0] chkSum; // Bit 8 is the borrow

    // Capture the accepted instruction
    always_ff @(posedge mclk)
    begin
        if (instrValid && !busy)
        begin
            opCap  <= instrWord[17:13];
            immCap <= instrWord[7:0];
            cinCap <= instrWord[14] & carryFlag;
        end
    end
    // Difference plus subtrahend overflows exactly on a borrow
    assign chkSum = {1'b0, result} + {1'b0, immCap} + {8'h00, cinCap};

    ////////////////////////////////////////
    sequence sTake;
        instrValid && !busy;
    endsequence
    sequence sRetire;
        busy ##1 (done && !busy);
    endsequence

    chk_take_retire: assert property (sTake |=> sRetire)
        else $error("Instruction did not retire two cycles after acceptance");
    chk_busy_single: assert property (busy |=> !busy)
        else $error("Busy stood longer than one cycle");
    chk_zero_match: assert property (done && !illegal |-> zeroFlag == (result == 8'h00))
        else $error("Zero flag disagrees with result");
    chk_carry_kept: assert property (sTake ##0 instrWord[16] |=> ##1 $stable(carryFlag))
        else $error("Carry changed by a move or logic operation");
    chk_load_value: assert property (sTake ##0 instrWord[17:13] == `SML_OP_LOAD_K
        |=> ##1 result == $past(instrWord[7:0], 2))
        else $error("Loaded constant not in result");
    chk_sub_borrow: assert property (done && !illegal && opCap[4:2] == 3'h0 && opCap[0]
        |-> carryFlag == chkSum[8])
        else $error("Carry is not the borrow of the subtraction");
    chk_pad_reject: assert property (sTake ##0 (!instrWord[13] && instrWord[2:0] != 3'h0)
        |=> ##1 done && illegal)
        else $error("Nonzero padding not rejected");
    chk_reject_hold: assert property (done && illegal
        |-> $stable(result) && $stable(carryFlag) && $stable(zeroFlag))
        else $error("Rejected instruction changed state");
endmodule : sml_alu_monitor

bind sml_alu sml_alu_monitor #(.DATA_W(DATA_W), .REG_COUNT(REG_COUNT)) mon (
    .mclk(mclk), .reset(reset), .instrValid(instrValid), .instrWord(instrWord),
    .peekIndex(peekIndex), .busy(busy), .done(done), .illegal(illegal), .result(result),
    .carryFlag(carryFlag), .zeroFlag(zeroFlag), .peekData(peekData)
);

// ---- sml_fetch_model.sv ----
// Fetch sequencer model that offers one instruction at a time.
// Assumes run is called just after a rising edge of mclk.
`timescale 1ns/1ps

module sml_fetch_model (
    input  wire logic   mclk,       // Clock
    input  wire logic   busy,       // Executing
    input  wire logic   done,       // Retired
    output logic        instrValid, // Offered
    output logic [17:0] instrWord   // Word
);
    // Idle at time zero
    initial
    begin
        instrValid = 1'b0;
        instrWord  = 18'h00000;
    end

    ////////////////////////////////////////
    // Offer a word after a gap, hold until taken, wait for retirement
    task automatic run(input sml_pkg::sml_instr_s w, input bit keep, input int gap,
                       output bit ok);
        int n;
        repeat (gap) @(posedge mclk) #1;
        instrValid = 1'b1;
        instrWord  = w;
        for (n = 0; busy && n < 8; n++) @(posedge mclk) #1;
        ok = !busy; // A busy that never drops counts as a failed offer
        @(posedge mclk) #1;
        if (keep) @(posedge mclk) #1;
        instrValid = 1'b0;
        instrWord  = ~w; // Released word never shows the old value
        for (n = 0; !done && n < 4; n++) @(posedge mclk) #1;
        ok = ok & done;
    endtask : run
endmodule : sml_fetch_model

// ---- tb.sv ----
// Self-checking bench for the execution block.
// Assumes the design, the checker and the fetch model are compiled first.
`timescale 1ns/1ps
`include "sml_map.svh"

module tb;
    logic        mclk, reset, instrValid, busy, done, illegal;
    logic        carryFlag, zeroFlag, refCarry, refZero;
    logic [17:0] instrWord;
    logic [4:0]  peekIndex;
    logic [7:0]  result, peekData, refRes;
    logic [7:0]  refReg [32];
    bit          ok;
    int          errCount, checkCount, i;

    // 25 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    sml_alu dut (.mclk(mclk), .reset(reset), .instrValid(instrValid), .instrWord(instrWord),
        .peekIndex(peekIndex), .busy(busy), .done(done), .illegal(illegal), .result(result),
        .carryFlag(carryFlag), .zeroFlag(zeroFlag), .peekData(peekData));
    sml_fetch_model fetch (.mclk(mclk), .busy(busy), .done(done), .instrValid(instrValid),
        .instrWord(instrWord));

    ////////////////////////////////////////
    task automatic print_verdict();
        if (errCount == 0 && checkCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    // Compare one byte, flags zero-extended
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        checkCount++;
        if (act !== exp)
        begin
            errCount++;
            $display("MISMATCH at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : chk
    // Reset, then expect cleared result and flags
    task automatic apply_reset(input int n);
        reset = 1'b1;
        repeat (n) @(posedge mclk) #1;
        reset = 1'b0;
        {refCarry, refZero, refRes} = 10'h000;
        foreach (refReg[k]) refReg[k] = 8'h00;
        chk(result, 8'h00);
        chk({6'h00, carryFlag, zeroFlag}, 8'h00);
    endtask : apply_reset
    // Run one instruction against the reference and judge status, result, flags and, when peek is set, peekData
    task automatic do_op(input logic [4:0] op, input logic [4:0] dst, input logic [7:0] low,
                         input bit keep, input bit peek);
        logic [7:0] a, s, r;
        logic       c, bad;
        a   = refReg[dst];
        s   = op[0] ? low : refReg[low[7:3]];
        bad = op[4] || (op[3:2] == 2'b01) || (!op[0] && low[2:0] != 3'h0);
        c   = refCarry;
        r   = a;
        if (!op[3])
            {c, r} = {1'b0, a} - {1'b0, s} - {8'h00, op[1] & refCarry};
        else
            case (op[2:1])
                2'h0: r = s;
                2'h1: r = a & s;
                2'h2: r = a | s;
                default: r = a ^ s;
            endcase
        if (!bad)
            {refReg[dst], refCarry, refZero, refRes} = {r, c, r == 8'h00, r};
        peekIndex = dst;
        fetch.run({op, dst, low}, keep, 0, ok);
        chk({7'h00, ok}, 8'h01);
        if (!ok)
            print_verdict();
        chk({7'h00, illegal}, {7'h00, bad});
        chk(result, refRes);
        chk({7'h00, carryFlag}, {7'h00, refCarry});
        chk({7'h00, zeroFlag}, {7'h00, refZero});
        if (peek)
        begin
            @(posedge mclk) #1;
            chk(peekData, refReg[dst]);
        end
    endtask : do_op

    ////////////////////////////////////////
    // Fill all 32 registers
    task automatic sc_load();
        for (i = 0; i < 32; i++)
            do_op(`SML_OP_LOAD_K, 5'(i), 8'(i * 29 + 3), 0, 1);
    endtask : sc_load
    // Subtract forms with borrow edges, carry left set
    task automatic sc_sub();
        do_op(`SML_OP_SUB, 5'd1, 8'h00, 0, 1);
        do_op(`SML_OP_SUB_K, 5'd2, 8'hFF, 0, 1);
        do_op(`SML_OP_SUB_B, 5'd3, 8'h20, 0, 1);
        do_op(`SML_OP_SUB_KB, 5'd7, 8'hCE, 0, 1);
        do_op(`SML_OP_SUB_KB, 5'd4, 8'h76, 0, 1);
        do_op(`SML_OP_SUB_K, 5'd8, 8'hEC, 0, 1);
    endtask : sc_sub
    // Move and logic forms with carry set beforehand
    task automatic sc_logic();
        for (i = 8; i < 16; i++)
            do_op(5'(i), 5'(i + 8), i[0] ? 8'h5A : {5'(i + 9), 3'h0}, 0, 1);
        do_op(`SML_OP_LOAD_K, 5'd31, 8'h00, 0, 1);
    endtask : sc_logic
    // Rejected encodings, refused retake, back-to-back stream
    task automatic sc_edge();
        do_op(`SML_OP_SUB, 5'd9, 8'h0D, 0, 1);
        do_op(`SML_OP_XOR, 5'd9, 8'h0B, 0, 1);
        do_op(5'h10, 5'd9, 8'h00, 0, 1);
        do_op(5'h05, 5'd9, 8'h00, 0, 1);
        do_op(`SML_OP_SUB_K, 5'd10, 8'h01, 1, 1);
        for (i = 0; i < 6; i++)
            do_op(i[0] ? `SML_OP_SUB_KB : `SML_OP_XOR_K, 5'd11, 8'h37, 0, i == 5);
    endtask : sc_edge

    // Main sequence
    initial
    begin
        errCount = 0;
        checkCount = 0;
        peekIndex = 5'h00;
        apply_reset(4);
        sc_load();
        sc_sub();
        sc_logic();
        sc_edge();
        apply_reset(1);
        peekIndex = 5'd12;
        repeat (2) @(posedge mclk) #1;
        chk(peekData, 8'h00);
        print_verdict();
    end
endmodule : tb
